// *** hdl/mgmt_pkg.sv ***
// Purpose: Shared constants and types for the serial management link and its two ends.
// Assumes: Clause 22 framing; station clock hclk at 25 MHz.
// Notes:   Station register offsets are byte addresses on the AHB-Lite bus.
package mgmt_pkg;
	// Frame layout, counted in management clock bits.
	localparam logic [5:0] PREAMBLE_BITS  = 6'h20;
	localparam logic [5:0] HDR_LAST       = 6'h0B;
	localparam logic [5:0] DATA_LAST      = 6'h0F;
	localparam logic [5:0] FRAME_LAST_BIT = 6'h3F;
	localparam logic [5:0] TA_FIRST_BIT   = 6'h2E;
	localparam logic [5:0] DATA_FIRST_BIT = 6'h30;
	localparam logic [1:0] START_CODE     = 2'h1;
	localparam logic [1:0] OP_READ        = 2'h2;
	localparam logic [1:0] OP_WRITE       = 2'h1;
	localparam logic [1:0] TA_WRITE       = 2'h2;
	localparam logic [1:0] TA_READ        = 2'h0;

	// Device register space.
	localparam int         STD_REGS           = 32;
	localparam int         EXT_DEPTH          = 32;
	localparam logic [4:0] REG_ACCESS_CONTROL = 5'h0D;
	localparam logic [4:0] REG_ADDRESS_DATA   = 5'h0E;
	localparam logic [4:0] TARGET_DEVICE_FIELD_GENERAL      = 5'h1F;
	localparam logic [1:0] FUNC_ADDRESS       = 2'h0;
	localparam logic [1:0] FUNC_DATA          = 2'h1;
	localparam logic [1:0] FUNC_INC_RW        = 2'h2;
	localparam logic [1:0] FUNC_INC_WR        = 2'h3;
	localparam int         FUNC_MSB           = 15;
	localparam int         FUNC_LSB           = 14;
	localparam logic [15:0] REG_RESET         = 16'h0000;
	localparam logic [4:0]  ADDR_RESET        = 5'h00;

	// Station clock divider: hclk periods per management clock half period.
	localparam int         HCLK_PERIOD_NS  = 40;
	localparam int         MDC_MIN_PERIOD_NS = 40;
	localparam int         MDC_DIV_MIN     = (MDC_MIN_PERIOD_NS + 2 * HCLK_PERIOD_NS - 1)
		/ (2 * HCLK_PERIOD_NS);
	localparam int         MDC_HALF_CYCLES = (MDC_DIV_MIN > 4) ? MDC_DIV_MIN : 4;
	localparam logic [2:0] MDC_HALF_LAST   = 3'(MDC_HALF_CYCLES - 1);

	// Station register byte offsets and fields.
	localparam logic [4:0] OFS_FRAME   = 5'h00;
	localparam logic [4:0] OFS_WDATA   = 5'h04;
	localparam logic [4:0] OFS_STATUS  = 5'h08;
	localparam logic [4:0] OFS_RDATA   = 5'h0C;
	localparam int         FRAME_READ  = 10;
	localparam int         STATUS_BUSY = 0;
	localparam int         STATUS_DONE = 1;

	typedef enum logic [2:0] {
		DEV_PREAMBLE = 3'b000,
		DEV_START    = 3'b001,
		DEV_HEADER   = 3'b010,
		DEV_TURN     = 3'b011,
		DEV_DATA     = 3'b100
	} dev_state_type;

	typedef enum logic [1:0] {
		SM_WAKE  = 2'b00,
		SM_IDLE  = 2'b01,
		SM_FRAME = 2'b10
	} sm_state_type;
endpackage

// *** hdl/mgmt_link_if.sv ***
// Purpose: Management clock and shared data line between station and device.
// Assumes: A pull-up holds the data line high when nobody drives it.
// Notes:   The line level is resolved here from the two output enables.
`timescale 1ns/1ps
`default_nettype none
interface mgmt_link_if;
	logic mdc;
	logic sm_mdio_o;
	logic sm_mdio_oe;
	logic dev_mdio_o;
	logic dev_mdio_oe;
	logic mdio;

	// Pull-up wins when both ends are released.
	assign mdio = dev_mdio_oe ? dev_mdio_o : (sm_mdio_oe ? sm_mdio_o : 1'h1);

	modport device (input mdc, input mdio, output dev_mdio_o, output dev_mdio_oe);
	modport station (output mdc, output sm_mdio_o, output sm_mdio_oe, input mdio);
endinterface
`default_nettype wire

// *** hdl/mgmt_device.sv ***
// Purpose: Management slave of the device, clocked by the management clock.
// Assumes: The station keeps its own duties: clock limit, idle after reset, write turnaround.
// Notes:   Extended space above register 31 is a small array indexed by pointer bits 4:0.
// Summary of operation
// - Management clock at most 25MHz, may stop.
// - Data line sampled on rising clock edge.
// - Station address latched from pins at reset; here latched once, at the third clock rise after reset.
// - Station idles one clock after reset.
// - Direct access to 32 16-bit registers.
// - Frames open with start pattern 01.
// - Nobody drives first read turnaround bit.
// - Device drives zero, then sixteen data bits.
// - Station drives 10 turnaround on writes.
// - Standard registers reachable directly or indirectly.
// - Indirect access to control/data registers ignored.
// - Indirect access only with device field 11111.
// - Function 00 accesses the address pointer.
// - Function 01 accesses data, pointer unchanged.
// - Function 10 increments after reads and writes.
// - Function 11 increments after writes only.
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mgmt_device (
	// Link
	mgmt_link_if.device               link,
	// Hard reset and address straps
	input  wire logic                 hresetn,
	input  wire logic [4:0]           station_address_pins,
	// User side
	output logic      [15:0]          control_word
);
	mgmt_pkg::dev_state_type state_r, state_nxt;
	logic [5:0]              cnt_r, cnt_nxt;
	logic [11:0]             hdr_r, hdr_nxt;
	logic [15:0]             shift_r, shift_nxt;
	logic                    rd_r, rd_nxt;
	logic                    oe_r, oe_nxt;
	logic                    out_r, out_nxt;
	logic [15:0]             ctrl_r, ctrl_nxt;
	logic [15:0]             ptr_r, ptr_nxt;
	logic [15:0]             std_r [mgmt_pkg::STD_REGS];
	logic [15:0]             ext_r [mgmt_pkg::EXT_DEPTH];
	logic                    std_we;
	logic                    ext_we;
	logic [4:0]              std_idx;
	logic [15:0]             wdata;
	logic [4:0]              strap_s1_r, strap_s2_r;
	logic                    vld1_r, vld2_r;
	logic [4:0]              addr_r, addr_nxt;
	logic                    addr_ok_r, addr_ok_nxt;
	logic                    match;
	logic                    target_device_field_ok;
	logic [1:0]              func;
	logic [4:0]              reg_sel;

	assign reg_sel  = hdr_r[4:0];
	assign match    = addr_ok_r && (hdr_r[9:5] == addr_r);
	assign target_device_field_ok = (ctrl_r[4:0] == mgmt_pkg::TARGET_DEVICE_FIELD_GENERAL);
	assign func     = ctrl_r[mgmt_pkg::FUNC_MSB:mgmt_pkg::FUNC_LSB];
	assign wdata    = {shift_r[14:0], link.mdio};

	// Read value for the frame's register field; indirect reads of 13 and 14 give zero.
	function automatic logic [15:0] reg_read(input logic [4:0] r);
		logic [15:0] v;
		v = std_r[r];
		if (r == mgmt_pkg::REG_ACCESS_CONTROL)
			v = ctrl_r;
		else if (r == mgmt_pkg::REG_ADDRESS_DATA)
		begin
			v = 16'h0000;
			if (target_device_field_ok && func == mgmt_pkg::FUNC_ADDRESS)
				v = ptr_r;
			else if (target_device_field_ok && ptr_r[15:5] != 11'h000)
				v = ext_r[ptr_r[4:0]];
			else if (target_device_field_ok && ptr_r[4:0] != mgmt_pkg::REG_ACCESS_CONTROL &&
				ptr_r[4:0] != mgmt_pkg::REG_ADDRESS_DATA)
				v = std_r[ptr_r[4:0]];
		end
		return v;
	endfunction

	// Frame decoder and register update; the address is frozen after its first capture.
	always_comb
	begin
		addr_nxt    = addr_r;
		addr_ok_nxt = addr_ok_r;
		if (vld2_r && !addr_ok_r)
		begin
			addr_nxt    = strap_s2_r;
			addr_ok_nxt = 1'h1;
		end
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		hdr_nxt   = hdr_r;
		shift_nxt = shift_r;
		rd_nxt    = rd_r;
		oe_nxt    = oe_r;
		out_nxt   = out_r;
		ctrl_nxt  = ctrl_r;
		ptr_nxt   = ptr_r;
		std_we    = 1'h0;
		ext_we    = 1'h0;
		std_idx   = reg_sel;
		case (state_r)
			// Count ones; a zero after a full preamble is the first start bit.
			mgmt_pkg::DEV_PREAMBLE:
			begin
				if (link.mdio)
				begin
					if (cnt_r != mgmt_pkg::PREAMBLE_BITS)
						cnt_nxt = cnt_r + 6'h01;
				end
				else if (cnt_r == mgmt_pkg::PREAMBLE_BITS)
				begin
					state_nxt = mgmt_pkg::DEV_START;
					cnt_nxt   = 6'h00;
				end
				else
					cnt_nxt = 6'h00;
			end
			mgmt_pkg::DEV_START:
			begin
				cnt_nxt   = 6'h00;
				state_nxt = link.mdio ? mgmt_pkg::DEV_HEADER : mgmt_pkg::DEV_PREAMBLE;
			end
			// Opcode, station address and register address, twelve bits.
			mgmt_pkg::DEV_HEADER:
			begin
				hdr_nxt = {hdr_r[10:0], link.mdio};
				cnt_nxt = cnt_r + 6'h01;
				if (cnt_r == mgmt_pkg::HDR_LAST)
				begin
					state_nxt = mgmt_pkg::DEV_TURN;
					cnt_nxt   = 6'h00;
				end
			end
			// First turnaround bit is left undriven; the zero goes out for the second.
			mgmt_pkg::DEV_TURN:
			begin
				if (cnt_r == 6'h00)
				begin
					rd_nxt    = match && (hdr_r[11:10] == mgmt_pkg::OP_READ);
					oe_nxt    = rd_nxt;
					out_nxt   = 1'h0;
					shift_nxt = reg_read(reg_sel);
					cnt_nxt   = 6'h01;
				end
				else
				begin
					if (rd_r)
					begin
						out_nxt   = shift_r[15];
						shift_nxt = {shift_r[14:0], 1'h0};
					end
					state_nxt = mgmt_pkg::DEV_DATA;
					cnt_nxt   = 6'h00;
				end
			end
			mgmt_pkg::DEV_DATA:
			begin
				cnt_nxt = cnt_r + 6'h01;
				if (rd_r)
				begin
					out_nxt   = shift_r[15];
					shift_nxt = {shift_r[14:0], 1'h0};
				end
				else
					shift_nxt = wdata;
				if (cnt_r == mgmt_pkg::DATA_LAST)
				begin
					state_nxt = mgmt_pkg::DEV_PREAMBLE;
					cnt_nxt   = 6'h00;
					oe_nxt    = 1'h0;
					rd_nxt    = 1'h0;
					if (match && hdr_r[11:10] == mgmt_pkg::OP_WRITE)
					begin
						if (reg_sel == mgmt_pkg::REG_ACCESS_CONTROL)
							ctrl_nxt = wdata;
						else if (reg_sel == mgmt_pkg::REG_ADDRESS_DATA)
						begin
							if (target_device_field_ok && func == mgmt_pkg::FUNC_ADDRESS)
								ptr_nxt = wdata;
							else if (target_device_field_ok)
							begin
								std_idx = ptr_r[4:0];
								if (ptr_r[15:5] != 11'h000)
									ext_we = 1'h1;
								else if (ptr_r[4:0] != mgmt_pkg::REG_ACCESS_CONTROL &&
									ptr_r[4:0] != mgmt_pkg::REG_ADDRESS_DATA)
									std_we = 1'h1;
								if (func[1])
									ptr_nxt = ptr_r + 16'h0001;
							end
						end
						else
							std_we = 1'h1;
					end
					else if (rd_r && reg_sel == mgmt_pkg::REG_ADDRESS_DATA && target_device_field_ok &&
						func == mgmt_pkg::FUNC_INC_RW)
						ptr_nxt = ptr_r + 16'h0001;
				end
			end
			default:
			begin
				state_nxt = mgmt_pkg::DEV_PREAMBLE;
				cnt_nxt   = 6'h00;
				oe_nxt    = 1'h0;
			end
		endcase
	end

	// Registers run only while the station clocks; a stopped clock simply freezes them.
	always_ff @(posedge link.mdc or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_r   <= mgmt_pkg::DEV_PREAMBLE;
			cnt_r     <= 6'h00;
			hdr_r     <= 12'h000;
			shift_r   <= mgmt_pkg::REG_RESET;
			rd_r      <= 1'h0;
			oe_r      <= 1'h0;
			out_r     <= 1'h0;
			ctrl_r    <= mgmt_pkg::REG_RESET;
			ptr_r     <= mgmt_pkg::REG_RESET;
			addr_r    <= mgmt_pkg::ADDR_RESET;
			addr_ok_r <= 1'h0;
			strap_s1_r <= mgmt_pkg::ADDR_RESET;
			strap_s2_r <= mgmt_pkg::ADDR_RESET;
			vld1_r     <= 1'h0;
			vld2_r     <= 1'h0;
			std_r      <= '{default: mgmt_pkg::REG_RESET};
			ext_r      <= '{default: mgmt_pkg::REG_RESET};
		end
		else
		begin
			state_r   <= state_nxt;
			cnt_r     <= cnt_nxt;
			hdr_r     <= hdr_nxt;
			shift_r   <= shift_nxt;
			rd_r      <= rd_nxt;
			oe_r      <= oe_nxt;
			out_r     <= out_nxt;
			ctrl_r    <= ctrl_nxt;
			ptr_r     <= ptr_nxt;
			addr_r    <= addr_nxt;
			addr_ok_r <= addr_ok_nxt;
			strap_s1_r <= station_address_pins; // Pins are not on this clock: two flops first.
			strap_s2_r <= strap_s1_r;
			vld1_r     <= 1'h1;
			vld2_r     <= vld1_r;
			if (std_we)
				std_r[std_idx] <= wdata;
			if (ext_we)
				ext_r[ptr_r[4:0]] <= wdata;
		end
	end

	// Outputs come straight from flops.
	assign link.dev_mdio_o  = out_r;
	assign link.dev_mdio_oe = oe_r;
	assign control_word     = std_r[0];
endmodule
`default_nettype wire

// *** hdl/station_manager.sv ***
// Purpose: Station end: AHB-Lite registers launch read and write frames on the link.
// Assumes: hclk at 25 MHz; one device on the link.
// Notes:   The management clock is divided from hclk and stops low between frames.
`timescale 1ns/1ps
`default_nettype none
module station_manager (
	// AHB-Lite slave
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Link
	mgmt_link_if.station     link
);
	mgmt_pkg::sm_state_type state_r, state_nxt;
	logic [2:0]   div_r, div_nxt;
	logic         mdc_r, mdc_nxt;
	logic [5:0]   bit_r, bit_nxt;
	logic [31:0]  tx_r, tx_nxt;
	logic         is_read_r, is_read_nxt;
	logic [15:0]  rx_r, rx_nxt;
	logic         out_r, out_nxt;
	logic         oe_r, oe_nxt;
	logic         ap_wr_r, ap_wr_nxt;
	logic [4:0]   ap_ofs_r, ap_ofs_nxt;
	logic [31:0]  hrdata_r, hrdata_nxt;
	logic [10:0]  frame_r, frame_nxt;
	logic [15:0]  wdata_r, wdata_nxt;
	logic [15:0]  rdata_r, rdata_nxt;
	logic         done_r, done_nxt;
	logic         mdio_s1_r, mdio_s2_r;
	logic         wrap, fall, rise, take, start;
	logic [5:0]   nb;

	// Zero-wait slave: every transfer completes OKAY in its first data-phase cycle.
	assign hreadyout = 1'h1;
	assign hresp     = 1'h0;
	assign hrdata    = hrdata_r;
	assign take      = hsel && htrans[1] && hready;
	assign start     = ap_wr_r && ap_ofs_r == mgmt_pkg::OFS_FRAME && state_r == mgmt_pkg::SM_IDLE;
	assign wrap      = state_r != mgmt_pkg::SM_IDLE && div_r == mgmt_pkg::MDC_HALF_LAST;
	assign fall      = wrap && mdc_r;
	assign rise      = wrap && !mdc_r;
	assign nb        = bit_r + 6'h01;

	// Data line from the device passes two flops before use.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mdio_s1_r <= 1'h1;
			mdio_s2_r <= 1'h1;
		end
		else
		begin
			mdio_s1_r <= link.mdio;
			mdio_s2_r <= mdio_s1_r;
		end
	end

	// Bus slave, clock divider and frame sequencer.
	always_comb
	begin
		state_nxt   = state_r;
		div_nxt     = div_r;
		mdc_nxt     = mdc_r;
		bit_nxt     = bit_r;
		tx_nxt      = tx_r;
		is_read_nxt = is_read_r;
		rx_nxt      = rx_r;
		out_nxt     = out_r;
		oe_nxt      = oe_r;
		frame_nxt   = frame_r;
		wdata_nxt   = wdata_r;
		rdata_nxt   = rdata_r;
		done_nxt    = done_r;
		ap_wr_nxt   = take && hwrite;
		ap_ofs_nxt  = haddr[4:0];
		hrdata_nxt  = hrdata_r;
		if (take && !hwrite)
		begin
			case (haddr[4:0])
				mgmt_pkg::OFS_FRAME:  hrdata_nxt = {21'h000000, frame_r};
				mgmt_pkg::OFS_WDATA:  hrdata_nxt = {16'h0000, wdata_r};
				mgmt_pkg::OFS_STATUS: hrdata_nxt = {30'h00000000, done_r,
					state_r != mgmt_pkg::SM_IDLE};
				mgmt_pkg::OFS_RDATA:  hrdata_nxt = {16'h0000, rdata_r};
				default:              hrdata_nxt = 32'h00000000;
			endcase
		end
		if (ap_wr_r && ap_ofs_r == mgmt_pkg::OFS_WDATA)
			wdata_nxt = hwdata[15:0];
		if (ap_wr_r && ap_ofs_r == mgmt_pkg::OFS_FRAME)
			frame_nxt = hwdata[10:0];
		if (ap_wr_r && ap_ofs_r == mgmt_pkg::OFS_STATUS && hwdata[mgmt_pkg::STATUS_DONE])
			done_nxt = 1'h0;
		// Divider runs except when idle, so the link clock stops between frames.
		if (state_r != mgmt_pkg::SM_IDLE)
		begin
			div_nxt = wrap ? 3'h0 : div_r + 3'h1;
			mdc_nxt = wrap ? !mdc_r : mdc_r;
		end
		case (state_r)
			// One full idle clock period after reset before any frame.
			mgmt_pkg::SM_WAKE:
				if (fall)
					state_nxt = mgmt_pkg::SM_IDLE;
			mgmt_pkg::SM_IDLE:
				if (start)
				begin
					is_read_nxt = hwdata[mgmt_pkg::FRAME_READ];
					tx_nxt      = {mgmt_pkg::START_CODE,
						is_read_nxt ? mgmt_pkg::OP_READ : mgmt_pkg::OP_WRITE,
						hwdata[9:0],
						is_read_nxt ? mgmt_pkg::TA_READ : mgmt_pkg::TA_WRITE,
						wdata_r};
					state_nxt   = mgmt_pkg::SM_FRAME;
					bit_nxt     = 6'h00;
					div_nxt     = 3'h0;
					out_nxt     = 1'h1;
					oe_nxt      = 1'h1;
				end
			// Bits change after the falling edge and are read just before the rising one.
			mgmt_pkg::SM_FRAME:
			begin
				if (rise && is_read_r && bit_r >= mgmt_pkg::DATA_FIRST_BIT)
					rx_nxt = {rx_r[14:0], mdio_s2_r};
				if (fall)
				begin
					if (bit_r == mgmt_pkg::FRAME_LAST_BIT)
					begin
						state_nxt = mgmt_pkg::SM_IDLE;
						oe_nxt    = 1'h0;
						out_nxt   = 1'h1;
						rdata_nxt = rx_r;
						done_nxt  = 1'h1;
					end
					else
					begin
						bit_nxt = nb;
						out_nxt = nb[5] ? tx_r[~nb[4:0]] : 1'h1;
						oe_nxt  = !(is_read_r && nb >= mgmt_pkg::TA_FIRST_BIT);
					end
				end
			end
			default:
				state_nxt = mgmt_pkg::SM_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_r   <= mgmt_pkg::SM_WAKE;
			div_r     <= 3'h0;
			mdc_r     <= 1'h0;
			bit_r     <= 6'h00;
			tx_r      <= 32'h00000000;
			is_read_r <= 1'h0;
			rx_r      <= 16'h0000;
			out_r     <= 1'h1;
			oe_r      <= 1'h0;
			ap_wr_r   <= 1'h0;
			ap_ofs_r  <= 5'h00;
			hrdata_r  <= 32'h00000000;
			frame_r   <= 11'h000;
			wdata_r   <= 16'h0000;
			rdata_r   <= 16'h0000;
			done_r    <= 1'h0;
		end
		else
		begin
			state_r   <= state_nxt;
			div_r     <= div_nxt;
			mdc_r     <= mdc_nxt;
			bit_r     <= bit_nxt;
			tx_r      <= tx_nxt;
			is_read_r <= is_read_nxt;
			rx_r      <= rx_nxt;
			out_r     <= out_nxt;
			oe_r      <= oe_nxt;
			ap_wr_r   <= ap_wr_nxt;
			ap_ofs_r  <= ap_ofs_nxt;
			hrdata_r  <= hrdata_nxt;
			frame_r   <= frame_nxt;
			wdata_r   <= wdata_nxt;
			rdata_r   <= rdata_nxt;
			done_r    <= done_nxt;
		end
	end

	assign link.mdc        = mdc_r;
	assign link.sm_mdio_o  = out_r;
	assign link.sm_mdio_oe = oe_r;
endmodule
`default_nettype wire

// *** verif/mgmt_link_asserts.sv ***
// Purpose: Watches the management link between station and device.
// Assumes: Sampled on hclk; the station divides the link clock from hclk.
// Notes:   Bit number is the count of link clock rises since the station took the line.
`timescale 1ns/1ps
`default_nettype none
module mgmt_link_asserts (
	// Station clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// Link signals
	input  wire logic mdc,
	input  wire logic sm_mdio_o,
	input  wire logic sm_mdio_oe,
	input  wire logic dev_mdio_o,
	input  wire logic dev_mdio_oe,
	input  wire logic mdio
);
	logic       mdc_r;
	logic       oe_r;
	logic [6:0] cnt_r;
	logic [6:0] cnt_nxt;
	logic       rise;
	logic [1:0] falls_r;
	logic [1:0] falls_nxt;

	// A rise is the first hclk sample that sees the link clock high.
	assign rise = mdc && !mdc_r;

	// The counter saturates so that a long idle time cannot wrap it.
	always_comb
	begin
		cnt_nxt = cnt_r;
		if (sm_mdio_oe && !oe_r)
			cnt_nxt = 7'h00;
		else if (rise && cnt_r != 7'h7F)
			cnt_nxt = cnt_r + 7'h01;
		falls_nxt = falls_r;
		if (!mdc && mdc_r && falls_r != 2'h3)
			falls_nxt = falls_r + 2'h1;
	end

	// History registers only.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mdc_r <= 1'h0;
			oe_r  <= 1'h0;
			cnt_r <= 7'h00;
			falls_r <= 2'h0;
		end
		else
		begin
			mdc_r <= mdc;
			oe_r  <= sm_mdio_oe;
			cnt_r <= cnt_nxt;
			falls_r <= falls_nxt;
		end
	end

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	no_contention_a: assert property (!(sm_mdio_oe && dev_mdio_oe))
		else $error("both ends drive the data line");
	clock_high_a: assert property (rise |-> mdc [*4] ##1 !mdc)
		else $error("link clock high time wrong");
	clock_idle_a: assert property ((cnt_r == 7'h40 && !mdc) |=> (!mdc || sm_mdio_oe))
		else $error("link clock runs between frames");
	preamble_ones_a: assert property ((sm_mdio_oe && cnt_r < 7'h20) |-> sm_mdio_o)
		else $error("preamble bit not one");
	start_code_a: assert property ((rise && cnt_r == 7'h20) |-> !mdio ##8 (rise && mdio))
		else $error("start pattern wrong");
	op_code_a: assert property ((rise && cnt_r == 7'h22) |-> ##8 (mdio != $past(mdio, 8)))
		else $error("opcode bits equal");
	write_turn_a: assert property ((rise && cnt_r == 7'h2E && sm_mdio_oe) |-> mdio ##8 !mdio)
		else $error("write turnaround wrong");
	read_turn_a: assert property ((rise && cnt_r == 7'h2E && !sm_mdio_oe) |-> !$past(dev_mdio_oe))
		else $error("device drives first turnaround bit");
	turn_zero_a: assert property ($rose(dev_mdio_oe) |-> !dev_mdio_o ##1 dev_mdio_oe [*8])
		else $error("device turnaround bit not zero");
	drive_window_a: assert property (dev_mdio_oe |-> (cnt_r >= 7'h2E && cnt_r <= 7'h40))
		else $error("device drives outside read data");
	frame_release_a: assert property ((cnt_r == 7'h40 && !mdc) |-> !dev_mdio_oe)
		else $error("device holds line after frame");
	wake_quiet_a: assert property ((falls_r == 2'h0) |-> !sm_mdio_oe)
		else $error("station drives before one idle clock after reset");

	cover property (rise && cnt_r == 7'h2E && sm_mdio_oe);
	cover property ($rose(dev_mdio_oe));
	cover property (rise && cnt_r == 7'h2F && !sm_mdio_oe && !dev_mdio_oe);
endmodule
`default_nettype wire

// *** verif/serial_mgmt_with_mmd_indirect_tb.sv ***
// Purpose: Self-checking bench for the station and device ends of the management link.
// Assumes: hclk at 25 MHz; the station makes the link clock from it.
// Notes:   A software model of the device registers predicts every read.
`timescale 1ns/1ps
`default_nettype none
module serial_mgmt_with_mmd_indirect_tb;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hready;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [4:0]  strap;
	logic [15:0] control_word;
	logic [15:0] regs [32];
	logic [15:0] ext [32];
	logic [15:0] ptr;
	int          num_errors;
	int          check_count;
	int          seed;
	int          i;
	logic [4:0]  r;
	logic [31:0] v;

	mgmt_link_if link ();
	assign hready = hreadyout;
	station_manager u_station_manager (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(link));
	mgmt_device u_mgmt_device (.link(link), .hresetn(hresetn), .station_address_pins(strap),
		.control_word(control_word));
	mgmt_link_asserts u_mgmt_link_asserts (.hclk(hclk), .hresetn(hresetn), .mdc(link.mdc),
		.sm_mdio_o(link.sm_mdio_o), .sm_mdio_oe(link.sm_mdio_oe), .dev_mdio_o(link.dev_mdio_o),
		.dev_mdio_oe(link.dev_mdio_oe), .mdio(link.mdio));

	task automatic test_done();
		if (num_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic hang();
		num_errors++;
		test_done();
	endtask

	task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask

	// Waits for an edge with hready high; a stuck bus ends the run.
	task automatic ready_wait();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'h1)
		begin
			n++;
			if (n == 50)
				hang();
			@(posedge hclk);
		end
	endtask

	// One single-word transfer: address phase, then data phase.
	task automatic ahb(input logic wr, input logic [4:0] a, input logic [31:0] wd,
		output logic [31:0] q);
		hsel   <= 1'h1;
		haddr  <= {27'h0000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		ready_wait();
		hsel   <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		ready_wait();
		q = hrdata;
	endtask

	// Device model: returns what a read would see and applies side effects.
	function automatic logic [15:0] model(input logic rd, input logic [4:0] phy,
		input logic [4:0] a, input logic [15:0] wd);
		logic [15:0] q;
		logic [15:0] c;
		c = regs[13];
		if (phy != strap)
			return 16'hFFFF;
		if (a != 5'h0E)
		begin
			q = regs[a];
			if (!rd)
				regs[a] = wd;
			return q;
		end
		if (c[4:0] != mgmt_pkg::TARGET_DEVICE_FIELD_GENERAL)
			return 16'h0000;
		q = ptr;
		if (c[15:14] == mgmt_pkg::FUNC_ADDRESS)
		begin
			if (!rd)
				ptr = wd;
			return q;
		end
		q = 16'h0000;
		if (ptr > 16'h001F)
			q = ext[ptr[4:0]];
		else if (ptr[4:0] != 5'h0D && ptr[4:0] != 5'h0E)
			q = regs[ptr[4:0]];
		if (!rd && ptr > 16'h001F)
			ext[ptr[4:0]] = wd;
		else if (!rd && ptr[4:0] != 5'h0D && ptr[4:0] != 5'h0E)
			regs[ptr[4:0]] = wd;
		if (c[15] && (!rd || !c[14]))
			ptr = ptr + 16'h0001;
		return q;
	endfunction

	// Runs one frame through the station registers and checks read data.
	task automatic xfer(input logic rd, input logic [4:0] phy, input logic [4:0] a,
		input logic [15:0] wd);
		logic [31:0] q;
		logic [15:0] e;
		int n;
		q = 32'h00000001;
		for (n = 0; q[0] !== 1'h0; n++)
		begin
			if (n == 2000)
				hang();
			ahb(1'h0, mgmt_pkg::OFS_STATUS, 32'h00000000, q);
		end
		ahb(1'h1, mgmt_pkg::OFS_WDATA, {16'h0000, wd}, q);
		ahb(1'h1, mgmt_pkg::OFS_FRAME, {21'h000000, rd, phy, a}, q);
		for (n = 0; q[1] !== 1'h1; n++)
		begin
			if (n == 2000)
				hang();
			ahb(1'h0, mgmt_pkg::OFS_STATUS, 32'h00000000, q);
		end
		ahb(1'h1, mgmt_pkg::OFS_STATUS, 32'h00000002, q);
		e = model(rd, phy, a, wd);
		if (rd)
			ahb(1'h0, mgmt_pkg::OFS_RDATA, 32'h00000000, q);
		if (rd)
			check("read data", {16'h0000, e}, q);
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		xfer(1'h0, strap, a, d);
	endtask

	task automatic rr(input logic [4:0] a);
		xfer(1'h1, strap, a, 16'h0000);
	endtask

	// Free-running station clock.
	initial
	begin
		hclk = 1'h0;
		forever #20 hclk = ~hclk;
	end

	// Main sequence; the strap is fixed before reset and held.
	initial
	begin
		seed = 32'h489450FE;
		strap = 5'($random(seed));
		num_errors = 0;
		check_count = 0;
		ptr = 16'h0000;
		regs = '{default: 16'h0000};
		ext = '{default: 16'h0000};
		hresetn = 1'h0;
		hsel = 1'h0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		repeat (4) @(posedge hclk);
		hresetn <= 1'h1;
		ahb(1'h1, 5'h10, 32'hFFFFFFFF, v);
		ahb(1'h0, 5'h10, 32'h00000000, v);
		check("unmapped", 32'h00000000, v);
		check("response", 32'h00000000, 32'(hresp));
		wr(5'h00, 16'($random(seed)));
		for (i = 0; i < 16; i++)
		begin
			r = 5'($random(seed));
			if (r == 5'h0D || r == 5'h0E)
				r = 5'h1F;
			xfer(i[0], strap, r, 16'($random(seed)));
		end
		check("control word", {16'h0000, regs[0]}, {16'h0000, control_word});
		xfer(1'h0, strap ^ 5'h01, 5'h01, 16'hA5A5);
		xfer(1'h1, strap ^ 5'h10, 5'h01, 16'h0000);
		rr(5'h01);
		wr(5'h0D, 16'h4000);
		wr(5'h0E, 16'h1234);
		rr(5'h0E);
		wr(5'h0D, 16'h001F);
		wr(5'h0E, 16'h0028);
		rr(5'h0E);
		wr(5'h0D, 16'h801F);
		wr(5'h0E, 16'($random(seed)));
		wr(5'h0E, 16'($random(seed)));
		wr(5'h0D, 16'h001F);
		rr(5'h0E);
		wr(5'h0E, 16'h0028);
		wr(5'h0D, 16'h801F);
		rr(5'h0E);
		rr(5'h0E);
		wr(5'h0D, 16'h001F);
		rr(5'h0E);
		wr(5'h0E, 16'h0028);
		wr(5'h0D, 16'hC01F);
		rr(5'h0E);
		rr(5'h0E);
		wr(5'h0E, 16'($random(seed)));
		wr(5'h0D, 16'h401F);
		rr(5'h0E);
		wr(5'h0E, 16'($random(seed)));
		rr(5'h0E);
		rr(5'h0E);
		wr(5'h0D, 16'h001F);
		rr(5'h0E);
		wr(5'h0E, 16'h0005);
		wr(5'h0D, 16'h401F);
		wr(5'h0E, 16'($random(seed)));
		rr(5'h05);
		rr(5'h0E);
		wr(5'h0D, 16'h001F);
		wr(5'h0E, 16'h000D);
		wr(5'h0D, 16'h401F);
		wr(5'h0E, 16'hBEEF);
		rr(5'h0E);
		rr(5'h0D);
		ahb(1'h0, mgmt_pkg::OFS_STATUS, 32'h00000000, v);
		check("status idle", 32'h00000000, v);
		test_done();
	end
endmodule
`default_nettype wire
